// File: logic/flash_status_regs.sv
// Purpose: the two status bytes of a serial flash, reached by opcodes
// Assumes: the array core reports busy, completion and suspend on clk_in;
//          non-volatile contents arrive on nv_image_in and stay stable
// Notes:   the array stores what nv_write_out hands it; this block only
//          mirrors the non-volatile bytes and runs the volatile copies
module flash_status_regs (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,

    // serial link pins
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    input wire logic guard_pin_n_in,
    output logic miso_out,
    output logic miso_oe_out,

    // array core
    input wire logic [15:0] nv_image_in,
    input wire logic core_busy_in,
    input wire logic op_done_in,
    input wire logic suspended_in,
    output logic nv_write_out,
    output logic [15:0] nv_data_out,

    // state seen by the array
    output logic write_latch_out,
    output logic busy_out,
    output logic granularity_sel_out,
    output logic range_origin_out,
    output logic [2:0] range_bits_out,
    output logic map_invert_out,
    output logic prot_none_out,
    output logic [3:0] otp_lock_out,
    output logic quad_lines_on_out,
    output logic pin_funcs_on_out
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        flash_status_pkg::ctl_state_e state;
        logic [7:0] nv1;
        logic [7:0] nv2;
        logic [7:0] vol1;
        logic [7:0] vol2;
        logic wlatch;
        logic vol_arm;
        logic have_cmd;
        logic [7:0] cmd;
        logic [1:0] nbytes;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] tx;
        logic miso;
        logic miso_oe;
        logic [flash_status_pkg::NVW_CNT_W-1:0] nvw_cnt;
        logic nv_write;
        logic [15:0] nv_data;
        logic [flash_status_pkg::SYNC_STAGES-1:0] wp_sync;
        logic wp_n;
        logic susp;
        logic busy;
        logic prot_none;
    } ctl_s;

    ctl_s r;
    ctl_s n;
    spi_byte_if link ();

    spi_byte_engine u_engine (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .sclk_in(sclk_in),
        .cs_n_in(cs_n_in),
        .mosi_in(mosi_in),
        .link(link.engine)
    );

    // ---------------------------------------------------------------
    // read image of a status byte
    // ---------------------------------------------------------------
    function automatic logic [7:0] read_image(input ctl_s s, input logic [7:0] op);
        logic [7:0] one;
        logic [7:0] two;
        one = s.vol1 & flash_status_pkg::ONE_VOL_MASK;
        one[1] = s.wlatch;
        one[0] = s.busy;
        two = (s.vol2 & flash_status_pkg::TWO_VOL_MASK) |
              (s.nv2 & flash_status_pkg::TWO_NV_MASK & ~flash_status_pkg::TWO_VOL_MASK);
        two = two | flash_status_pkg::TWO_LOCK_ZERO;
        two[flash_status_pkg::TWO_SUSPEND] = s.susp;
        if (op == flash_status_pkg::OP_READ_TWO) begin
            read_image = two;
        end else begin
            read_image = one;
        end
    endfunction

    function automatic logic is_read(input logic [7:0] op);
        is_read = (op == flash_status_pkg::OP_READ_ONE) ||
                  (op == flash_status_pkg::OP_READ_TWO);
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [7:0] nv1_new;
        logic [7:0] nv2_new;
        logic wr_ok;
        nv1_new = '0;
        nv2_new = '0;
        wr_ok = 1'b0;
        n = r;
        n.nv_write = 1'b0;
        n.wp_sync = {r.wp_sync[1:0], guard_pin_n_in};
        if (r.wp_sync[1] == r.wp_sync[2]) begin
            n.wp_n = r.wp_sync[2];
        end
        n.susp = suspended_in;

        case (r.state)
            flash_status_pkg::ST_LOAD: begin
                // the image is sampled after reset release, never under reset
                n.nv1 = nv_image_in[7:0] & flash_status_pkg::ONE_NV_MASK;
                n.nv2 = (nv_image_in[15:8] & flash_status_pkg::TWO_NV_MASK) |
                        flash_status_pkg::TWO_LOCK_ZERO;
                n.vol1 = n.nv1 & flash_status_pkg::ONE_VOL_MASK;
                n.vol2 = n.nv2 & flash_status_pkg::TWO_VOL_MASK;
                n.state = flash_status_pkg::ST_RUN;
            end
            flash_status_pkg::ST_RUN: begin
            end
            flash_status_pkg::ST_NV_WRITE: begin
                n.nvw_cnt = r.nvw_cnt - flash_status_pkg::NVW_LAST;
                if (r.nvw_cnt == flash_status_pkg::NVW_LAST) begin
                    n.state = flash_status_pkg::ST_RUN;
                    n.wlatch = 1'b0;
                end
            end
            default: begin
                n.state = flash_status_pkg::ST_LOAD;
            end
        endcase

        // completion of an array operation ends the write enable
        if (op_done_in) begin
            n.wlatch = 1'b0;
        end

        if (r.state != flash_status_pkg::ST_LOAD) begin
            if (link.frame_start) begin
                n.have_cmd = 1'b0;
                n.nbytes = '0;
                n.miso_oe = 1'b0;
            end

            if (link.rx_valid && !r.have_cmd) begin
                n.have_cmd = 1'b1;
                n.cmd = link.rx_byte;
                if (is_read(link.rx_byte)) begin
                    n.tx = read_image(r, link.rx_byte);
                end else if (!r.busy) begin
                    // while busy only status reads are taken
                    if (link.rx_byte == flash_status_pkg::OP_WRITE_EN) begin
                        n.wlatch = 1'b1;
                        n.vol_arm = 1'b0;
                    end else if (link.rx_byte == flash_status_pkg::OP_VOL_WRITE_EN) begin
                        n.vol_arm = 1'b1;
                    end else if (link.rx_byte != flash_status_pkg::OP_WRITE_STATUS) begin
                        n.vol_arm = 1'b0;
                    end
                end
            end else if (link.rx_valid) begin
                if (is_read(r.cmd)) begin
                    // repeated reads refresh with the live value
                    n.tx = read_image(r, r.cmd);
                end else if (r.nbytes == 2'h0) begin
                    n.d1 = link.rx_byte;
                    n.nbytes = 2'h1;
                end else if (r.nbytes == 2'h1) begin
                    n.d2 = link.rx_byte;
                    n.nbytes = 2'h2;
                end
            end

            if (link.shift_out) begin
                n.miso = r.tx[7];
                n.tx = {r.tx[6:0], 1'b0};
                n.miso_oe = r.have_cmd && is_read(r.cmd);
            end

            if (link.frame_end) begin
                n.miso_oe = 1'b0;
                n.have_cmd = 1'b0;
                if (r.have_cmd && r.cmd == flash_status_pkg::OP_WRITE_STATUS &&
                    r.nbytes != 2'h0 && !r.busy) begin
                    wr_ok = flash_status_pkg::status_write_ok(
                        r.nv1[flash_status_pkg::ONE_GUARD_A],
                        r.nv2[flash_status_pkg::TWO_GUARD_B],
                        r.vol2[flash_status_pkg::TWO_QUAD],
                        r.wp_n);
                    // data at the latch, busy and suspend positions is dropped
                    nv1_new = r.d1 & flash_status_pkg::ONE_NV_MASK;
                    nv2_new = r.nv2;
                    if (r.nbytes == 2'h2) begin
                        nv2_new = (r.d2 & flash_status_pkg::TWO_NV_MASK &
                                   ~flash_status_pkg::TWO_LOCK_MASK) |
                                  ((r.d2 | r.nv2) & flash_status_pkg::TWO_LOCK_MASK);
                    end
                    nv2_new = nv2_new | flash_status_pkg::TWO_LOCK_ZERO;
                    if (r.vol_arm) begin
                        if (wr_ok) begin
                            n.vol1 = nv1_new & flash_status_pkg::ONE_VOL_MASK;
                            n.vol2 = nv2_new & flash_status_pkg::TWO_VOL_MASK;
                        end
                    end else if (r.wlatch) begin
                        if (wr_ok) begin
                            n.nv1 = nv1_new;
                            n.nv2 = nv2_new;
                            n.vol1 = nv1_new & flash_status_pkg::ONE_VOL_MASK;
                            n.vol2 = nv2_new & flash_status_pkg::TWO_VOL_MASK;
                            n.nv_write = 1'b1;
                            n.nv_data = {nv2_new, nv1_new};
                            n.nvw_cnt = flash_status_pkg::NV_WRITE_CYC;
                            n.state = flash_status_pkg::ST_NV_WRITE;
                        end else begin
                            n.wlatch = 1'b0;
                        end
                    end
                end
                if (r.have_cmd && r.cmd == flash_status_pkg::OP_WRITE_STATUS) begin
                    n.vol_arm = 1'b0;
                end
            end
        end

        n.busy = core_busy_in || (n.state == flash_status_pkg::ST_NV_WRITE);
        n.prot_none = (n.vol1[flash_status_pkg::ONE_RANGE_HI:flash_status_pkg::ONE_RANGE_LO] ==
                       flash_status_pkg::RANGE_NONE) &&
                      !n.vol2[flash_status_pkg::TWO_INVERT];
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            r <= '0;
            r.state <= flash_status_pkg::ST_LOAD;
            r.nv1 <= flash_status_pkg::ONE_RESET;
            r.nv2 <= flash_status_pkg::TWO_RESET;
            r.vol1 <= flash_status_pkg::ONE_RESET;
            r.vol2 <= flash_status_pkg::TWO_RESET & flash_status_pkg::TWO_VOL_MASK;
            r.wp_n <= 1'b1;
            r.prot_none <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all straight from state flops except pin_funcs_on_out, an inverted flop
    // ---------------------------------------------------------------
    assign miso_out = r.miso;
    assign miso_oe_out = r.miso_oe;
    assign nv_write_out = r.nv_write;
    assign nv_data_out = r.nv_data;
    assign write_latch_out = r.wlatch;
    assign busy_out = r.busy;
    assign granularity_sel_out = r.vol1[flash_status_pkg::ONE_GRAN];
    assign range_origin_out = r.vol1[flash_status_pkg::ONE_ORIGIN];
    assign range_bits_out =
        r.vol1[flash_status_pkg::ONE_RANGE_HI:flash_status_pkg::ONE_RANGE_LO];
    assign map_invert_out = r.vol2[flash_status_pkg::TWO_INVERT];
    assign prot_none_out = r.prot_none;
    assign otp_lock_out =
        r.nv2[flash_status_pkg::TWO_LOCK_HI:flash_status_pkg::TWO_LOCK_LO];
    assign quad_lines_on_out = r.vol2[flash_status_pkg::TWO_QUAD];
    assign pin_funcs_on_out = !r.vol2[flash_status_pkg::TWO_QUAD];

endmodule

// File: logic/flash_status_pkg.sv
// Purpose: constants, types and helpers for the two flash status bytes
// Assumes: one 250 MHz clock, serial pins sampled through synchronisers
// Notes:   register access is by opcode over the serial link only
//
// Behaviour
// - status one bit 7 lets the guard pin block status writes; lockdown comes from status two bit 0
// - status one bit 6 picks 64-kB block or 4-kB sector range granularity
// - status one bit 5 grows the protected range from top or from bottom
// - range field at zero with the map not inverted leaves the whole array unprotected
// - write latch gates the start of every program, erase or non-volatile status write
// - busy bit reads one while any embedded operation runs
// - status two bit 7 reads one while an operation is suspended
// - status two bit 6 inverts the protection map
// - status two bits 5 to 2 are one-time lock bits, never cleared
// - lock bit for security register zero always reads one
// - quad enable turns on extra data lines and disables pin functions
// - status two bit 0 changes what guard select a means
// - protection fields keep non-volatile and volatile copies, status one defaults zero
// - volatile copies load from non-volatile ones at power-up, then steer behaviour, except guard select a, taken from the non-volatile copy
// - only write enable sets the latch; completion clears it
// - volatile enable directly before write status updates volatile copies only
// - status writes gated by both guard selects and, without quad, the guard pin
package flash_status_pkg;

    // ---------------------------------------------------------------
    // opcodes
    // ---------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_EN = 8'h06;
    localparam logic [7:0] OP_VOL_WRITE_EN = 8'h50;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ_ONE = 8'h05;
    localparam logic [7:0] OP_READ_TWO = 8'h35;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int ONE_GUARD_A = 7;
    localparam int ONE_GRAN = 6;
    localparam int ONE_ORIGIN = 5;
    localparam int ONE_RANGE_HI = 4;
    localparam int ONE_RANGE_LO = 2;
    localparam int TWO_SUSPEND = 7;
    localparam int TWO_INVERT = 6;
    localparam int TWO_LOCK_HI = 5;
    localparam int TWO_LOCK_LO = 2;
    localparam int TWO_QUAD = 1;
    localparam int TWO_GUARD_B = 0;

    // ---------------------------------------------------------------
    // masks and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] ONE_NV_MASK = 8'hFC;
    localparam logic [7:0] TWO_NV_MASK = 8'h7F;
    localparam logic [7:0] ONE_VOL_MASK = 8'hFC;
    localparam logic [7:0] TWO_VOL_MASK = 8'h42;
    localparam logic [7:0] TWO_LOCK_MASK = 8'h3C;
    localparam logic [7:0] TWO_LOCK_ZERO = 8'h04;
    localparam logic [7:0] ONE_RESET = 8'h00;
    localparam logic [7:0] TWO_RESET = 8'h04;
    localparam logic [2:0] RANGE_NONE = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int NV_WRITE_NS = 1000;
    localparam int NV_WRITE_CYC_I = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NVW_CNT_W = 9;
    localparam logic [NVW_CNT_W-1:0] NV_WRITE_CYC = NVW_CNT_W'(NV_WRITE_CYC_I);
    localparam logic [NVW_CNT_W-1:0] NVW_LAST = 9'h001;
    localparam int SYNC_STAGES = 3;
    localparam int LINK_PINS = 3;
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS_N = 1;
    localparam int PIN_MOSI = 2;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_RUN = 2'b01,
        ST_NV_WRITE = 2'b10
    } ctl_state_e;

    // status writes allowed unless locked down or guarded by a low pin
    function automatic logic status_write_ok(input logic guard_a, input logic guard_b,
                                             input logic quad_on, input logic guard_pin_n);
        status_write_ok = !guard_b && !(guard_a && !quad_on && !guard_pin_n);
    endfunction

endpackage

// File: logic/spi_byte_if.sv
// Purpose: byte-level link between the serial engine and the status control
// Assumes: all signals on clk_in; pulses last one cycle
// Notes:   shift_out marks a falling serial clock edge while selected
interface spi_byte_if;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic frame_start;
    logic frame_end;
    logic shift_out;

    modport engine (output rx_valid, output rx_byte, output frame_start,
                    output frame_end, output shift_out);
    modport ctl (input rx_valid, input rx_byte, input frame_start,
                 input frame_end, input shift_out);
endinterface

// File: logic/spi_byte_engine.sv
// Purpose: synchronise serial pins and assemble received bytes
// Assumes: mode 0 framing, serial clock well below clk_in / 4
// Notes:   each pin passes three flops; a change counts when stages 2 and 3 agree
module spi_byte_engine (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // serial pins
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    // byte link
    spi_byte_if.engine link
);

    typedef struct packed {
        logic [flash_status_pkg::LINK_PINS-1:0][flash_status_pkg::SYNC_STAGES-1:0] sync;
        logic [flash_status_pkg::LINK_PINS-1:0] filt;
        logic sel;
        logic [2:0] cnt;
        logic [7:0] shreg;
        logic rx_valid;
        logic [7:0] rx_byte;
        logic fstart;
        logic fend;
        logic shout;
    } eng_s;

    eng_s r;
    eng_s n;
    logic [flash_status_pkg::LINK_PINS-1:0] pins;

    assign pins = {mosi_in, cs_n_in, sclk_in};

    always_comb begin
        n = r;
        n.rx_valid = 1'b0;
        n.fstart = 1'b0;
        n.fend = 1'b0;
        n.shout = 1'b0;
        for (int i = 0; i < flash_status_pkg::LINK_PINS; i++) begin
            n.sync[i] = {r.sync[i][1:0], pins[i]};
            if (r.sync[i][1] == r.sync[i][2]) begin
                n.filt[i] = r.sync[i][2];
            end
        end
        if (r.filt[flash_status_pkg::PIN_CS_N] && !n.filt[flash_status_pkg::PIN_CS_N]) begin
            n.sel = 1'b1;
            n.fstart = 1'b1;
            n.cnt = '0;
        end else if (!r.filt[flash_status_pkg::PIN_CS_N] &&
                     n.filt[flash_status_pkg::PIN_CS_N]) begin
            n.sel = 1'b0;
            n.fend = r.sel;
        end else if (r.sel) begin
            if (!r.filt[flash_status_pkg::PIN_SCLK] && n.filt[flash_status_pkg::PIN_SCLK]) begin
                n.shreg = {r.shreg[6:0], r.filt[flash_status_pkg::PIN_MOSI]};
                n.cnt = r.cnt + 3'h1;
                if (r.cnt == flash_status_pkg::BIT_LAST) begin
                    n.rx_valid = 1'b1;
                    n.rx_byte = {r.shreg[6:0], r.filt[flash_status_pkg::PIN_MOSI]};
                end
            end else if (r.filt[flash_status_pkg::PIN_SCLK] &&
                         !n.filt[flash_status_pkg::PIN_SCLK]) begin
                n.shout = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign link.rx_valid = r.rx_valid;
    assign link.rx_byte = r.rx_byte;
    assign link.frame_start = r.fstart;
    assign link.frame_end = r.fend;
    assign link.shift_out = r.shout;

endmodule

// File: verif/flash_status_regs_properties.sv
// Purpose: port-level properties of the flash status block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound onto every instance of the status block
module flash_status_regs_properties (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // observed ports
    input wire logic [15:0] nv_image_in,
    input wire logic core_busy_in,
    input wire logic nv_write_out,
    input wire logic write_latch_out,
    input wire logic busy_out,
    input wire logic granularity_sel_out,
    input wire logic range_origin_out,
    input wire logic [2:0] range_bits_out,
    input wire logic map_invert_out,
    input wire logic prot_none_out,
    input wire logic [3:0] otp_lock_out,
    input wire logic quad_lines_on_out,
    input wire logic pin_funcs_on_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    property p_lock0;
        otp_lock_out[0];
    endproperty
    a_lock0: assert property (p_lock0) else $error("lock bit zero low");
    property p_pins;
        pin_funcs_on_out == !quad_lines_on_out;
    endproperty
    a_pins: assert property (p_pins) else $error("pin functions disagree with quad");
    property p_prot;
        prot_none_out == (range_bits_out == 3'h0 && !map_invert_out);
    endproperty
    a_prot: assert property (p_prot) else $error("unprotected flag wrong");
    property p_sticky;
        ($past(otp_lock_out) & ~otp_lock_out) == 4'h0;
    endproperty
    a_sticky: assert property (p_sticky) else $error("lock bit cleared");
    property p_load;
        $fell(srst_in) |-> ##2 (range_bits_out == nv_image_in[4:2]
            && granularity_sel_out == nv_image_in[6] && range_origin_out == nv_image_in[5]
            && map_invert_out == nv_image_in[14] && quad_lines_on_out == nv_image_in[9]);
    endproperty
    a_load: assert property (p_load) else $error("volatile copies not loaded");
    property p_core;
        core_busy_in |=> busy_out;
    endproperty
    a_core: assert property (p_core) else $error("busy missed array activity");
    property p_nvbusy;
        nv_write_out |=> busy_out [*8];
    endproperty
    a_nvbusy: assert property (p_nvbusy) else $error("busy not held for status store");
    property p_nvlatch;
        nv_write_out |-> write_latch_out;
    endproperty
    a_nvlatch: assert property (p_nvlatch) else $error("store started without latch");
endmodule

bind flash_status_regs flash_status_regs_properties u_props (.*);

// File: verif/spi_host_model.sv
// Purpose: host side of the serial link, sends opcode frames
// Assumes: half serial period of 8 clk_in cycles, generous for the pin filter
// Notes:   mosi shows the inverse of its last bit while deselected
module spi_host_model (
    // clock
    input wire logic clk_in,
    // serial pins
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // opcode then nd bytes, byte one first; rd keeps the last 8 bits seen
    task automatic xfer(input logic [7:0] op, input int nd, input logic [15:0] wd,
                        output logic [7:0] rd);
        logic [23:0] sh;
        sh = {op, wd[7:0], wd[15:8]};
        rd = 8'h00;
        wait_clk(1);
        cs_n_out = 1'b0;
        for (int i = 0; i < 8 * (nd + 1); i++) begin
            sclk_out = 1'b0;
            mosi_out = sh[23 - i];
            wait_clk(8);
            rd = {rd[6:0], miso_in};
            sclk_out = 1'b1;
            wait_clk(8);
        end
        sclk_out = 1'b0;
        wait_clk(8);
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
        wait_clk(10);
    endtask
endmodule

// File: verif/tb.sv
// Purpose: self-checking bench for the flash status block
// Assumes: 250 MHz clock, frames from the serial host model
// Notes:   volatile writes run from a table, odd cases follow
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic guard_pin_n_in = 1'b1;
    logic core_busy_in = 1'b0;
    logic op_done_in = 1'b0;
    logic suspended_in = 1'b0;
    logic [15:0] nv_image_in = 16'h400C;
    logic sclk_in, cs_n_in, mosi_in, miso_out, miso_oe_out, nv_write_out;
    logic write_latch_out, busy_out, granularity_sel_out, range_origin_out;
    logic map_invert_out, prot_none_out, quad_lines_on_out, pin_funcs_on_out;
    logic [15:0] nv_data_out;
    logic [15:0] nv_cap;
    logic [2:0] range_bits_out;
    logic [3:0] otp_lock_out;
    logic [7:0] rd;
    int n_errors = 0;
    int total_checks = 0;
    int nv_seen = 0;
    typedef struct {logic [7:0] w1; logic [7:0] w2; logic [7:0] r1; logic [7:0] r2;} row_s;
    row_s rows [4] = '{'{8'h1F, 8'h42, 8'h1C, 8'h46}, '{8'h63, 8'hC0, 8'h60, 8'h44},
                       '{8'hE3, 8'h82, 8'hE0, 8'h06}, '{8'h00, 8'h00, 8'h00, 8'h04}};
    always #2 clk_in = ~clk_in;
    flash_status_regs DUT (.*);
    spi_host_model host (.clk_in(clk_in), .miso_in(miso_out), .sclk_out(sclk_in),
        .cs_n_out(cs_n_in), .mosi_out(mosi_in));
    // ---------------------------------------------------------------
    // store pulses are one cycle wide, so capture them here
    // ---------------------------------------------------------------
    always @(posedge clk_in) begin
        if (nv_write_out === 1'b1) begin
            nv_seen <= nv_seen + 1;
            nv_cap <= nv_data_out;
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic vol_write(input logic [15:0] w);
        host.xfer(flash_status_pkg::OP_VOL_WRITE_EN, 0, 16'h0000, rd);
        host.xfer(flash_status_pkg::OP_WRITE_STATUS, 2, w, rd);
    endtask
    task automatic rd_chk(input logic [7:0] op, input logic [7:0] exp, input logic [7:0] m);
        host.xfer(op, 1, 16'h0000, rd);
        chk("status byte", {8'h00, exp & m}, {8'h00, rd & m});
        chk("oe idle", 16'h0000, {15'h0000, miso_oe_out});
    endtask
    task automatic pulse_edge;
        @(posedge clk_in);
        #1;
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (4) pulse_edge();
        srst_in = 1'b0;
        repeat (10) pulse_edge();
        chk("lock bits", 16'h0001, {12'h000, otp_lock_out});
        rd_chk(flash_status_pkg::OP_READ_ONE, 8'h0C, 8'hFF);
        rd_chk(flash_status_pkg::OP_READ_TWO, 8'h44, 8'hFF);
        foreach (rows[i]) begin
            vol_write({rows[i].w2, rows[i].w1});
            chk("range", {13'h0000, rows[i].r1[4:2]}, {13'h0000, range_bits_out});
            chk("gran origin", {14'h0000, rows[i].r1[6:5]},
                {14'h0000, granularity_sel_out, range_origin_out});
            chk("invert quad", {14'h0000, rows[i].r2[6], rows[i].r2[1]},
                {14'h0000, map_invert_out, quad_lines_on_out});
            rd_chk(flash_status_pkg::OP_READ_ONE, rows[i].r1, 8'hFF);
            rd_chk(flash_status_pkg::OP_READ_TWO, rows[i].r2, 8'hFF);
        end
        host.xfer(flash_status_pkg::OP_WRITE_STATUS, 1, 16'h0024, rd);
        chk("store without latch", 16'h0000, 16'(nv_seen));
        host.xfer(flash_status_pkg::OP_WRITE_EN, 0, 16'h0000, rd);
        chk("latch set", 16'h0001, {15'h0000, write_latch_out});
        host.xfer(flash_status_pkg::OP_WRITE_STATUS, 2, 16'h00A4, rd);
        chk("store count", 16'h0001, 16'(nv_seen));
        chk("store data", 16'h04A4, nv_cap);
        rd_chk(flash_status_pkg::OP_READ_ONE, 8'h03, 8'h03);
        for (int i = 0; i < 400 && busy_out !== 1'b0; i++) pulse_edge();
        repeat (2) pulse_edge();
        chk("latch after store", 16'h0000, {15'h0000, write_latch_out});
        vol_write(16'h008C);
        rd_chk(flash_status_pkg::OP_READ_ONE, 8'h8C, 8'hFF);
        // guard pin low blocks while quad is off, has no say once quad is on
        guard_pin_n_in = 1'b0;
        vol_write(16'h009C);
        chk("guarded range", 16'h0003, {13'h0000, range_bits_out});
        guard_pin_n_in = 1'b1;
        vol_write(16'h028C);
        guard_pin_n_in = 1'b0;
        vol_write(16'h029C);
        chk("quad range", 16'h0007, {13'h0000, range_bits_out});
        guard_pin_n_in = 1'b1;
        core_busy_in = 1'b1;
        suspended_in = 1'b1;
        host.xfer(flash_status_pkg::OP_WRITE_EN, 0, 16'h0000, rd);
        chk("latch while busy", 16'h0000, {15'h0000, write_latch_out});
        rd_chk(flash_status_pkg::OP_READ_TWO, 8'h80, 8'h80);
        core_busy_in = 1'b0;
        suspended_in = 1'b0;
        host.xfer(flash_status_pkg::OP_WRITE_EN, 0, 16'h0000, rd);
        op_done_in = 1'b1;
        pulse_edge();
        op_done_in = 1'b0;
        repeat (2) pulse_edge();
        chk("latch after done", 16'h0000, {15'h0000, write_latch_out});
        wrap_up();
    end
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end
endmodule
